/* rtl/bdm_byte_ram.sv */
/*
 * Flip-flop byte storage with one write port and a combinational read
 * by index. Assumes the caller never addresses beyond DEPTH.
 */
`timescale 1ns/1ps
module bdm_byte_ram #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic core_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrIndex,
	input wire logic [7:0] wrData,
	input wire logic [AW-1:0] rdIndex,
	output logic [7:0] rdData
);

	logic [7:0] mem [DEPTH];

	// contents are undefined after reset, as for any data RAM
	always_ff @(posedge core_clk) begin
		if (wrEn) begin
			mem[wrIndex] <= wrData;
		end
	end

	assign rdData = mem[rdIndex];

endmodule : bdm_byte_ram

/* rtl/bdm_core_regs.sv */
/*
 * Banked data memory with the mirrored core registers, the status
 * register with its protected flags, and reads of program memory words
 * through the two pointers.
 * Assumes the instruction datapath issues at most one file access per
 * cycle, holds off while busy is high, and supplies ALU flag results
 * in the same cycle as the write that they accompany.
 */
`timescale 1ns/1ps
module bdm_core_regs #(
	parameter int GPR_BANKS = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [6:0] reqAddr,
	input wire logic [7:0] reqWdata,
	input wire logic reqLoadAcc,
	input wire logic [2:0] affectFlags,
	input wire logic aluZero,
	input wire logic aluDigitCarry,
	input wire logic aluCarry,
	input wire logic aluSubtract,
	input wire logic watchdogClearInstr,
	input wire logic sleepInstr,
	input wire logic watchdogTimeout,
	output logic progRead,
	output logic [14:0] progAddr,
	input wire logic [13:0] progData,
	output logic busy,
	output logic rdValid,
	output logic [7:0] rdData,
	output logic [7:0] accumulator,
	output logic [7:0] statusFlags,
	output logic [4:0] activeBank
);

	localparam int GPR_DEPTH = GPR_BANKS * bdm_pkg::GPR_PER_BANK;
	localparam int GPR_AW = $clog2(GPR_DEPTH);
	localparam int COM_AW = $clog2(bdm_pkg::COMMON_SIZE);
	localparam int FETCH_CW = (bdm_pkg::PROG_EXTRA_CYCLES > 1) ?
		$clog2(bdm_pkg::PROG_EXTRA_CYCLES) : 1;

	typedef enum logic {
		BDM_IDLE,
		BDM_FETCH
	} bdm_state_t;

	bdm_state_t state_reg;
	logic [14:0] progAddr_reg;
	logic fetchLoadAcc_reg;
	logic [7:0] rdData_reg;
	logic rdValid_reg;
	logic [7:0] acc_reg;
	logic [4:0] bank_reg;
	logic [7:0] pcLow_reg;
	logic [7:0] pcLatch_reg;
	logic [7:0] intCtl_reg;
	logic [1:0] toPd_reg;
	logic [2:0] arith_reg;
	logic [FETCH_CW-1:0] fetchCnt_reg;

	logic [15:0] ptr0;
	logic [15:0] ptr1;
	logic [15:0] selPtr;
	logic viaPointer;
	logic toProgram;
	logic outOfRange;
	logic [11:0] dataAddr;
	logic [4:0] tgtBank;
	logic [6:0] tgtOfs;
	logic accept;
	logic doWrite;
	logic coreWr;
	logic [7:0] statusWord;
	logic [7:0] coreRd;
	logic [7:0] memRd;
	logic isGpr;
	logic isCommon;
	logic [6:0] gprOfs;
	logic [GPR_AW-1:0] gprIndex;
	logic [COM_AW-1:0] comIndex;
	logic [7:0] gprRd;
	logic [7:0] comRd;
	logic fetchLast;

	assign accept = reqValid && (state_reg == BDM_IDLE);

	// both indirect ports resolve through their own pointer
	always_comb begin
		viaPointer = (reqAddr == bdm_pkg::OFS_INDIRECT_PORT_0) ||
			(reqAddr == bdm_pkg::OFS_INDIRECT_PORT_1);
		selPtr = (reqAddr == bdm_pkg::OFS_INDIRECT_PORT_1) ? ptr1 : ptr0;
		toProgram = viaPointer && selPtr[bdm_pkg::PTR_PROG_BIT];
		// only the traditional banked window is decoded here
		outOfRange = viaPointer && (selPtr[14:12] != 3'h0);
		dataAddr = viaPointer ? selPtr[11:0] : {bank_reg, reqAddr};
		tgtBank = dataAddr[11:7];
		tgtOfs = dataAddr[6:0];
	end

	always_comb begin
		isGpr = (tgtOfs >= bdm_pkg::GPR_START) && (tgtOfs < bdm_pkg::COMMON_START) &&
			(32'(tgtBank) < GPR_BANKS) && !outOfRange;
		isCommon = (tgtOfs >= bdm_pkg::COMMON_START) && !outOfRange;
		gprOfs = tgtOfs - bdm_pkg::GPR_START;
		gprIndex = GPR_AW'(32'(tgtBank) * bdm_pkg::GPR_PER_BANK + 32'(gprOfs));
		comIndex = tgtOfs[COM_AW-1:0];
	end

	// a program-memory target never reaches any data store
	assign doWrite = accept && reqWrite && !toProgram;
	assign coreWr = doWrite && !outOfRange && (tgtOfs < bdm_pkg::SFR_START);

	bdm_byte_ram #(
		.DEPTH(GPR_DEPTH),
		.AW(GPR_AW)
	) u_gpr (
		.core_clk(core_clk),
		.wrEn(doWrite && isGpr),
		.wrIndex(gprIndex),
		.wrData(reqWdata),
		.rdIndex(gprIndex),
		.rdData(gprRd)
	);

	// one physical copy, so every bank sees the same bytes
	bdm_byte_ram #(
		.DEPTH(bdm_pkg::COMMON_SIZE),
		.AW(COM_AW)
	) u_common (
		.core_clk(core_clk),
		.wrEn(doWrite && isCommon),
		.wrIndex(comIndex),
		.wrData(reqWdata),
		.rdIndex(comIndex),
		.rdData(comRd)
	);

	bdm_ptr_pair u_ptr0 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wrLow(coreWr && (tgtOfs == bdm_pkg::OFS_POINTER0_LOW)),
		.wrHigh(coreWr && (tgtOfs == bdm_pkg::OFS_POINTER0_HIGH)),
		.wrData(reqWdata),
		.ptrValue(ptr0)
	);

	bdm_ptr_pair u_ptr1 (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wrLow(coreWr && (tgtOfs == bdm_pkg::OFS_POINTER1_LOW)),
		.wrHigh(coreWr && (tgtOfs == bdm_pkg::OFS_POINTER1_HIGH)),
		.wrData(reqWdata),
		.ptrValue(ptr1)
	);

	assign statusWord = {3'h0, toPd_reg, arith_reg};

	// the indirect ports read through themselves give zero
	always_comb begin
		unique case (tgtOfs)
			bdm_pkg::OFS_PROGRAM_COUNTER_LOW: coreRd = pcLow_reg;
			bdm_pkg::OFS_STATUS_FLAGS: coreRd = statusWord;
			bdm_pkg::OFS_POINTER0_LOW: coreRd = ptr0[7:0];
			bdm_pkg::OFS_POINTER0_HIGH: coreRd = ptr0[15:8];
			bdm_pkg::OFS_POINTER1_LOW: coreRd = ptr1[7:0];
			bdm_pkg::OFS_POINTER1_HIGH: coreRd = ptr1[15:8];
			bdm_pkg::OFS_BANK_SELECT: coreRd = {3'h0, bank_reg};
			bdm_pkg::OFS_WORKING_ACCUMULATOR: coreRd = acc_reg;
			bdm_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH: coreRd = pcLatch_reg;
			bdm_pkg::OFS_INTERRUPT_CONTROL: coreRd = intCtl_reg;
			default: coreRd = bdm_pkg::RESET_BYTE;
		endcase
	end

	always_comb begin
		if (outOfRange) begin
			memRd = bdm_pkg::RESET_BYTE;
		end else if (tgtOfs < bdm_pkg::SFR_START) begin
			memRd = coreRd;
		end else if (isCommon) begin
			memRd = comRd;
		end else if (isGpr) begin
			memRd = gprRd;
		end else begin
			memRd = bdm_pkg::RESET_BYTE;
		end
	end

	// program fetch: address goes out for one cycle, word captured then
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= BDM_IDLE;
		end else begin
			unique case (state_reg)
				BDM_IDLE: begin
					if (accept && !reqWrite && toProgram) begin
						state_reg <= BDM_FETCH;
					end
				end
				BDM_FETCH: begin
					if (fetchLast) begin
						state_reg <= BDM_IDLE;
					end
				end
			endcase
		end
	end

	// the stall lasts as many cycles as the program word needs to arrive
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fetchCnt_reg <= '0;
		end else if ((state_reg == BDM_FETCH) && !fetchLast) begin
			fetchCnt_reg <= fetchCnt_reg + 1'b1;
		end else begin
			fetchCnt_reg <= '0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			progAddr_reg <= 15'h0000;
			fetchLoadAcc_reg <= 1'b0;
		end else if (accept && !reqWrite && toProgram) begin
			progAddr_reg <= selPtr[14:0];
			fetchLoadAcc_reg <= reqLoadAcc;
		end
	end

	assign progRead = (state_reg == BDM_FETCH);
	assign progAddr = progAddr_reg;
	assign busy = (state_reg == BDM_FETCH);
	assign fetchLast = (32'(fetchCnt_reg) == bdm_pkg::PROG_EXTRA_CYCLES - 1);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_reg <= bdm_pkg::RESET_BYTE;
			rdValid_reg <= 1'b0;
		end else if ((state_reg == BDM_FETCH) && fetchLast) begin
			rdData_reg <= progData[7:0];
			rdValid_reg <= 1'b1;
		end else if (accept && !reqWrite && !toProgram) begin
			rdData_reg <= memRd;
			rdValid_reg <= 1'b1;
		end else begin
			rdValid_reg <= 1'b0;
		end
	end

	assign rdData = rdData_reg;
	assign rdValid = rdValid_reg;

	// a direct write to the accumulator and a load by a read never meet:
	// the load belongs to a read request, the write to a write request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= bdm_pkg::RESET_BYTE;
		end else if (state_reg == BDM_FETCH) begin
			if (fetchLoadAcc_reg) begin
				acc_reg <= progData[7:0];
			end
		end else if (accept && !reqWrite && !toProgram && reqLoadAcc) begin
			acc_reg <= memRd;
		end else if (coreWr && (tgtOfs == bdm_pkg::OFS_WORKING_ACCUMULATOR)) begin
			acc_reg <= reqWdata;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_reg <= bdm_pkg::RESET_BANK;
		end else if (coreWr && (tgtOfs == bdm_pkg::OFS_BANK_SELECT)) begin
			bank_reg <= reqWdata[4:0];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pcLow_reg <= bdm_pkg::RESET_BYTE;
			pcLatch_reg <= bdm_pkg::RESET_BYTE;
			intCtl_reg <= bdm_pkg::RESET_BYTE;
		end else if (coreWr) begin
			if (tgtOfs == bdm_pkg::OFS_PROGRAM_COUNTER_LOW) begin
				pcLow_reg <= reqWdata;
			end
			if (tgtOfs == bdm_pkg::OFS_PROGRAM_COUNTER_LATCH_HIGH) begin
				pcLatch_reg <= reqWdata;
			end
			if (tgtOfs == bdm_pkg::OFS_INTERRUPT_CONTROL) begin
				intCtl_reg <= reqWdata;
			end
		end
	end

	// arithmetic flags: flag logic outranks the written value bit by bit
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			arith_reg <= bdm_pkg::RESET_ARITH;
		end else begin
			if (affectFlags[bdm_pkg::STAT_Z_BIT]) begin
				arith_reg[bdm_pkg::STAT_Z_BIT] <= aluZero;
			end else if (coreWr && (tgtOfs == bdm_pkg::OFS_STATUS_FLAGS)) begin
				arith_reg[bdm_pkg::STAT_Z_BIT] <= reqWdata[bdm_pkg::STAT_Z_BIT];
			end
			if (affectFlags[bdm_pkg::STAT_DC_BIT]) begin
				arith_reg[bdm_pkg::STAT_DC_BIT] <= aluSubtract ? !aluDigitCarry
					: aluDigitCarry;
			end else if (coreWr && (tgtOfs == bdm_pkg::OFS_STATUS_FLAGS)) begin
				arith_reg[bdm_pkg::STAT_DC_BIT] <= reqWdata[bdm_pkg::STAT_DC_BIT];
			end
			if (affectFlags[bdm_pkg::STAT_C_BIT]) begin
				arith_reg[bdm_pkg::STAT_C_BIT] <= aluSubtract ? !aluCarry
					: aluCarry;
			end else if (coreWr && (tgtOfs == bdm_pkg::OFS_STATUS_FLAGS)) begin
				arith_reg[bdm_pkg::STAT_C_BIT] <= reqWdata[bdm_pkg::STAT_C_BIT];
			end
		end
	end

	// timeout and power-down change only through their hardware events;
	// a timeout in the same cycle as a clear instruction wins, as the event
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			toPd_reg <= bdm_pkg::RESET_TO_PD;
		end else begin
			if (watchdogTimeout) begin
				toPd_reg[1] <= 1'b0;
			end else if (watchdogClearInstr || sleepInstr) begin
				toPd_reg[1] <= 1'b1;
			end
			if (sleepInstr) begin
				toPd_reg[0] <= 1'b0;
			end else if (watchdogClearInstr) begin
				toPd_reg[0] <= 1'b1;
			end
		end
	end

	assign accumulator = acc_reg;
	assign statusFlags = statusWord;
	assign activeBank = bank_reg;

endmodule : bdm_core_regs

/* rtl/bdm_pkg.sv */
/*
 * Shared constants for the banked data memory and core register block:
 * core register offsets, bank partitioning, status field positions,
 * reset values and the program-memory fetch timing.
 * Assumes a single instruction clock and an 8-bit data path.
 */
// Summary of operation
// - pointer high bit7 selects program memory read
// - indirect program read loads low byte only
// - indirect writes never modify program memory
// - program memory reads take one extra cycle
// - data space is 32 banks of 128
// - bank: 12 core, 20 special, 80 general
// - 16 shared bytes identical in every bank
// - direct accesses use latest bank select value
// - unimplemented data locations read as zero
// - memory reachable directly and via both pointers
// - core registers mirrored at every bank start
// - flag-affecting writes leave Z, DC, C to logic
// - timeout and power-down flags ignore all writes
// - subtraction carries act as active-low borrows
package bdm_pkg;

	localparam int NUM_BANKS = 32;
	localparam int BANK_SIZE = 128;
	localparam int GPR_PER_BANK = 80;
	localparam int COMMON_SIZE = 16;

	localparam logic [6:0] OFS_INDIRECT_PORT_0 = 7'h00;
	localparam logic [6:0] OFS_INDIRECT_PORT_1 = 7'h01;
	localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
	localparam logic [6:0] OFS_STATUS_FLAGS = 7'h03;
	localparam logic [6:0] OFS_POINTER0_LOW = 7'h04;
	localparam logic [6:0] OFS_POINTER0_HIGH = 7'h05;
	localparam logic [6:0] OFS_POINTER1_LOW = 7'h06;
	localparam logic [6:0] OFS_POINTER1_HIGH = 7'h07;
	localparam logic [6:0] OFS_BANK_SELECT = 7'h08;
	localparam logic [6:0] OFS_WORKING_ACCUMULATOR = 7'h09;
	localparam logic [6:0] OFS_PROGRAM_COUNTER_LATCH_HIGH = 7'h0A;
	localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0B;

	localparam logic [6:0] SFR_START = 7'h0C;
	localparam logic [6:0] GPR_START = 7'h20;
	localparam logic [6:0] COMMON_START = 7'h70;

	localparam int PTR_PROG_BIT = 15;
	localparam int STAT_TO_BIT = 4;
	localparam int STAT_PD_BIT = 3;
	localparam int STAT_Z_BIT = 2;
	localparam int STAT_DC_BIT = 1;
	localparam int STAT_C_BIT = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_POINTER = 16'h0000;
	localparam logic [4:0] RESET_BANK = 5'h00;
	localparam logic [1:0] RESET_TO_PD = 2'h3;
	localparam logic [2:0] RESET_ARITH = 3'h0;

	localparam int PROG_EXTRA_CYCLES = 1;

endpackage : bdm_pkg

/* rtl/bdm_ptr_pair.sv */
/*
 * One 16-bit pointer held as a low and a high byte register.
 * Assumes byte writes are already decoded by the caller.
 */
`timescale 1ns/1ps
module bdm_ptr_pair (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wrLow,
	input wire logic wrHigh,
	input wire logic [7:0] wrData,
	output logic [15:0] ptrValue
);

	logic [7:0] low_reg;
	logic [7:0] high_reg;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_reg <= bdm_pkg::RESET_POINTER[7:0];
		end else if (wrLow) begin
			low_reg <= wrData;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_reg <= bdm_pkg::RESET_POINTER[15:8];
		end else if (wrHigh) begin
			high_reg <= wrData;
		end
	end

	assign ptrValue = {high_reg, low_reg};

endmodule : bdm_ptr_pair

/* tb/bdm_core_regs_assertions.sv */
/*
 * Port checks for the core register block.
 * Assumes it is bound to bdm_core_regs and sees its ports only.
 */
`timescale 1ns/1ps
module bdm_core_regs_assertions (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [6:0] reqAddr,
	input wire logic [7:0] reqWdata,
	input wire logic [2:0] affectFlags,
	input wire logic aluZero,
	input wire logic aluCarry,
	input wire logic aluSubtract,
	input wire logic watchdogClearInstr,
	input wire logic sleepInstr,
	input wire logic watchdogTimeout,
	input wire logic progRead,
	input wire logic [13:0] progData,
	input wire logic busy,
	input wire logic rdValid,
	input wire logic [7:0] rdData,
	input wire logic [7:0] statusFlags,
	input wire logic [4:0] activeBank
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic wrTake;
	logic anyPulse;
	logic [7:0] progLow;
	logic [4:0] wdLow;
	assign wrTake = reqValid && reqWrite && !busy;
	assign anyPulse = watchdogClearInstr || sleepInstr || watchdogTimeout;
	assign progLow = progData[7:0];
	assign wdLow = reqWdata[4:0];
	property p_progData; progRead |=> rdValid && rdData == $past(progLow); endproperty
	a_progData: assert property (p_progData) else $error("program byte mismatch");
	property p_busyOne; busy |=> !busy; endproperty
	a_busyOne: assert property (p_busyOne) else $error("fetch stall too long");
	property p_busyFetch; progRead == busy; endproperty
	a_busyFetch: assert property (p_busyFetch) else $error("stall without fetch");
	property p_statHigh; statusFlags[7:5] == 3'h0; endproperty
	a_statHigh: assert property (p_statHigh) else $error("status top bits set");
	property p_timeout; watchdogTimeout |=> !statusFlags[4]; endproperty
	a_timeout: assert property (p_timeout) else $error("timeout flag kept");
	property p_clear;
		watchdogClearInstr && !watchdogTimeout && !sleepInstr |=> statusFlags[4:3] == 2'h3;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not set flags");
	property p_sleep;
		sleepInstr && !watchdogTimeout && !watchdogClearInstr |=> statusFlags[4:3] == 2'h2;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
	property p_noWrite; wrTake && reqAddr == 7'h03 && !anyPulse |=> $stable(statusFlags[4:3]);
	endproperty
	a_noWrite: assert property (p_noWrite) else $error("reset flags written");
	property p_zero; affectFlags[2] |=> statusFlags[2] == $past(aluZero); endproperty
	a_zero: assert property (p_zero) else $error("zero flag not from logic");
	property p_carry;
		affectFlags[0] |=> statusFlags[0] == ($past(aluCarry) ^ $past(aluSubtract));
	endproperty
	a_carry: assert property (p_carry) else $error("carry polarity wrong");
	property p_bank; wrTake && reqAddr == 7'h08 |=> activeBank == $past(wdLow); endproperty
	a_bank: assert property (p_bank) else $error("bank not updated");
	c_prog: cover property (progRead);
	c_timeout: cover property (watchdogTimeout);
	c_bank: cover property (wrTake && reqAddr == 7'h08);
endmodule : bdm_core_regs_assertions

/* tb/bdm_core_regs_tb.sv */
/*
 * Self-checking bench for the core register block.
 * Assumes the program memory model on the fetch port.
 */
`timescale 1ns/1ps
module bdm_core_regs_tb;
	logic core_clk, rst_n, reqValid, reqWrite, reqLoadAcc, aluZero, aluDigitCarry, aluCarry;
	logic aluSubtract, watchdogClearInstr, sleepInstr, watchdogTimeout, progRead, busy, rdValid;
	int busyCnt = 0;
	logic [6:0] reqAddr, o;
	logic [7:0] reqWdata, rdData, accumulator, statusFlags, v, st;
	logic [2:0] affectFlags;
	logic [14:0] progAddr;
	logic [13:0] progData;
	logic [4:0] activeBank;
	logic [15:0] p;
	logic [31:0] seed = 32'h0000E206;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	int bk[5] = '{0, 1, 3, 4, 31};
	logic [2:0] pl[4] = '{3'h1, 3'h2, 3'h5, 3'h4};
	logic [1:0] ex[4] = '{2'h1, 2'h2, 2'h1, 2'h3};

	bdm_core_regs #(.GPR_BANKS(4)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
		.reqLoadAcc(reqLoadAcc), .affectFlags(affectFlags), .aluZero(aluZero),
		.aluDigitCarry(aluDigitCarry), .aluCarry(aluCarry), .aluSubtract(aluSubtract),
		.watchdogClearInstr(watchdogClearInstr), .sleepInstr(sleepInstr),
		.watchdogTimeout(watchdogTimeout), .progRead(progRead), .progAddr(progAddr),
		.progData(progData), .busy(busy), .rdValid(rdValid), .rdData(rdData),
		.accumulator(accumulator), .statusFlags(statusFlags), .activeBank(activeBank));
	bdm_prog_rom rom (.core_clk(core_clk), .progRead(progRead), .progAddr(progAddr),
		.progData(progData));

	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			test_done();
		end
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd
	// alu packs {subtract, carry, digit carry, zero}
	function automatic logic [7:0] expStat(input logic [7:0] old, d, input logic [2:0] af,
		input logic [3:0] alu);
		return {3'h0, old[4:3], af[2] ? alu[0] : d[2], af[1] ? alu[1] ^ alu[3] : d[1],
			af[0] ? alu[2] ^ alu[3] : d[0]};
	endfunction : expStat
	task automatic chk(input string n, input logic [7:0] e, g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input logic la,
		input logic [2:0] af, input logic [3:0] alu);
		@(posedge core_clk);
		reqValid <= 1'h1;
		reqWrite <= w;
		reqAddr <= a;
		reqWdata <= d;
		reqLoadAcc <= la;
		affectFlags <= af;
		{aluSubtract, aluCarry, aluDigitCarry, aluZero} <= alu;
		@(posedge core_clk);
		reqValid <= 1'h0;
		affectFlags <= 3'h0;
		#1;
		busyCnt = 0;
		while (busy === 1'h1) begin
			busyCnt++;
			@(posedge core_clk);
			#1;
		end
	endtask : acc
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		acc(1'h1, a, d, 1'h0, 3'h0, 4'h0);
	endtask : wr
	task automatic rd(input string n, input logic [6:0] a, input logic [7:0] e);
		acc(1'h0, a, 8'h00, 1'h0, 3'h0, 4'h0);
		chk(n, e, rdData);
	endtask : rd
	task automatic pulse(input logic [2:0] q);
		@(posedge core_clk);
		{watchdogClearInstr, sleepInstr, watchdogTimeout} <= q;
		@(posedge core_clk);
		{watchdogClearInstr, sleepInstr, watchdogTimeout} <= 3'h0;
		#1;
	endtask : pulse
	task automatic test_done();
		if (error_cnt == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done

	initial begin
		{rst_n, reqValid, reqWrite, reqLoadAcc, aluZero, aluDigitCarry, aluCarry} = 7'h00;
		{aluSubtract, watchdogClearInstr, sleepInstr, watchdogTimeout} = 4'h0;
		reqAddr = 7'h00;
		reqWdata = 8'h00;
		affectFlags = 3'h0;
		st = 8'h18;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		#1;
		chk("statusFlags", st, statusFlags);
		wr(7'h09, 8'h5A);
		foreach (bk[i]) begin
			v = rnd();
			o = 7'h20 + 7'(v % 80);
			wr(7'h08, 8'(bk[i]));
			chk("activeBank", 8'(bk[i]), {3'h0, activeBank});
			wr(o, v);
			rd("gpr", o, bk[i] < 4 ? v : 8'h00);
			wr(7'h70, 8'(bk[i]));
			rd("coreMirror", 7'h09, 8'h5A);
			rd("sfr", 7'h0C, 8'h00);
		end
		wr(7'h08, 8'h00);
		rd("common", 7'h70, 8'h1F);
		p = 16'h0100 + 16'(o);
		wr(7'h06, p[7:0]);
		wr(7'h07, p[15:8]);
		wr(7'h01, v);
		wr(7'h04, p[7:0]);
		wr(7'h05, p[15:8]);
		rd("ptr0", 7'h00, v);
		wr(7'h08, 8'h02);
		rd("direct", o, v);
		repeat (4) begin
			p = {1'h1, 7'(rnd()), rnd()};
			wr(7'h04, p[7:0]);
			wr(7'h05, p[15:8]);
			acc(1'h0, 7'h00, 8'h00, 1'h1, 3'h0, 4'h0);
			chk("busy", 8'(bdm_pkg::PROG_EXTRA_CYCLES), 8'(busyCnt));
			chk("progAddr", p[7:0], progAddr[7:0]);
			chk("progByte", p[7:0] ^ 8'hA5, rdData);
			chk("accumulator", p[7:0] ^ 8'hA5, accumulator);
			wr(7'h00, ~rdData);
			chk("writeStall", 8'h00, 8'(busyCnt));
			rd("progKeep", 7'h00, p[7:0] ^ 8'hA5);
			chk("keepStall", 8'(bdm_pkg::PROG_EXTRA_CYCLES), 8'(busyCnt));
		end
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 8'hFF : rnd();
			o = (i == 0) ? 7'h00 : 7'(rnd());
			st = expStat(st, v, o[2:0], o[6:3]);
			acc(1'h1, 7'h03, v, 1'h0, o[2:0], o[6:3]);
			chk("status", st, statusFlags);
		end
		foreach (pl[i]) begin
			pulse(pl[i]);
			st[4:3] = ex[i];
			chk("statusPulse", st, statusFlags);
		end
		test_done();
	end
endmodule : bdm_core_regs_tb

bind bdm_core_regs bdm_core_regs_assertions chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
	.affectFlags(affectFlags), .aluZero(aluZero), .aluCarry(aluCarry),
	.aluSubtract(aluSubtract), .watchdogClearInstr(watchdogClearInstr),
	.sleepInstr(sleepInstr), .watchdogTimeout(watchdogTimeout), .progRead(progRead),
	.progData(progData), .busy(busy), .rdValid(rdValid), .rdData(rdData),
	.statusFlags(statusFlags), .activeBank(activeBank));

/* tb/bdm_prog_rom.sv */
/*
 * Program memory seen by the fetch port: combinational word lookup.
 * Assumes the word is only trusted while progRead is high.
 */
`timescale 1ns/1ps
module bdm_prog_rom (
	input wire logic core_clk,
	input wire logic progRead,
	input wire logic [14:0] progAddr,
	output logic [13:0] progData
);
	logic tick = 1'h0;
	always @(posedge core_clk) tick <= ~tick;
	// read-only: no write path exists
	// outside a fetch the bus churns so a stale word cannot pass
	assign progData = progRead ? {progAddr[13:8], progAddr[7:0] ^ 8'hA5}
		: ({14{tick}} ^ 14'h2AAA);
endmodule : bdm_prog_rom
